//--- include/pmbcr_regs.svh
// Contract
// - On/off command at 01h, volatile byte, default 00h, not the enable source unless on/off config bit 3 is set.
// - On/off config at 02h, default 16h, storable; combines control pin and command.
// - Write to 03h clears all fault status; nothing to read back.
// - Write protection at 10h, default 00h allows all writes, storable.
// - Writes to 11h or 15h save storable settings to nonvolatile memory.
// - Writes to 12h or 16h reload storable settings from nonvolatile memory.
// - Code 19h is read-only and returns B0h.
// - Code 1Bh masks status bits from alert; default masks power good only.
// - Code 20h is read-only and returns 17h, exponent 2^-9.
// - Ceiling at 24h limits any output setpoint above it.
// - Restored ceiling is 034Dh, 069Ah or 0C00h for ratio 1, 0.5, 0.25.
// - Floor at 2Bh raises any output setpoint below it; with the limits crossed, a setpoint above the ceiling gets the ceiling instead.
// - Restored floor is 00B3h, 0166h or 02CCh for ratio 1, 0.5, 0.25.
// - Slew rate at 27h, default D03Ch, volatile.
// - Sense scaling ratio at 29h, default F004h, storable.
// - Input start threshold at 35h, default F012h, storable.
// - Input stop threshold at 36h, default F010h, storable.
// - Multi-byte data low byte first; bits within a byte MSB first.
// - Error check byte used only when the host clocks it before stop.
`ifndef PMBCR_REGS_SVH
`define PMBCR_REGS_SVH

`define PMBCR_CMD_OP        8'h01
`define PMBCR_CMD_ONOFF     8'h02
`define PMBCR_CMD_CLR       8'h03
`define PMBCR_CMD_WP        8'h10
`define PMBCR_CMD_STORE_D   8'h11
`define PMBCR_CMD_RESTORE_D 8'h12
`define PMBCR_CMD_STORE_U   8'h15
`define PMBCR_CMD_RESTORE_U 8'h16
`define PMBCR_CMD_CAP       8'h19
`define PMBCR_CMD_MASK      8'h1b
`define PMBCR_CMD_MODE      8'h20
`define PMBCR_CMD_VCMD      8'h21
`define PMBCR_CMD_VMAX      8'h24
`define PMBCR_CMD_RATE      8'h27
`define PMBCR_CMD_SCALE     8'h29
`define PMBCR_CMD_VMIN      8'h2b
`define PMBCR_CMD_INPUT_START_THRESHOLD    8'h35
`define PMBCR_CMD_INPUT_STOP_THRESHOLD   8'h36

`define PMBCR_OP_RST        8'h00
`define PMBCR_ONOFF_RST     8'h16
`define PMBCR_WP_RST        8'h00
`define PMBCR_CAP_VAL       8'hb0
`define PMBCR_MASK_RST      8'h08
`define PMBCR_MODE_VAL      8'h17
`define PMBCR_VCMD_RST      16'h0100
`define PMBCR_VMAX_S1       16'h034d
`define PMBCR_VMAX_S05      16'h069a
`define PMBCR_VMAX_S025     16'h0c00
`define PMBCR_VMIN_S1       16'h00b3
`define PMBCR_VMIN_S05      16'h0166
`define PMBCR_VMIN_S025     16'h02cc
`define PMBCR_RATE_RST      16'hd03c
`define PMBCR_SCALE_S1      16'hf004
`define PMBCR_SCALE_S05     16'hf002
`define PMBCR_SCALE_S025    16'hf001
`define PMBCR_INPUT_START_THRESHOLD_RST    16'hf012
`define PMBCR_INPUT_STOP_THRESHOLD_RST   16'hf010

`define PMBCR_WP_NONE       8'h80
`define PMBCR_WP_OPONLY     8'h40
`define PMBCR_WP_CFG        8'h20

`define PMBCR_OP_ON_BIT     7
`define PMBCR_CFG_PU_BIT    4
`define PMBCR_CFG_CMD_BIT   3
`define PMBCR_CFG_CP_BIT    2
`define PMBCR_CFG_POL_BIT   1

`define PMBCR_CRC_POLY      8'h07

`endif

//--- include/pmbcr_pkg.sv
package pmbcr_pkg;
	typedef enum logic [1:0] {
		PMBCR_IDLE,
		PMBCR_RX,
		PMBCR_TX,
		PMBCR_SKIP
	} pmbcr_state_t;

	// Data length of a command: none, byte, word, or unsupported
	typedef enum logic [1:0] {
		PMBCR_LEN_SEND,
		PMBCR_LEN_BYTE,
		PMBCR_LEN_WORD,
		PMBCR_LEN_BAD
	} pmbcr_len_t;
endpackage : pmbcr_pkg

//--- rtl/pmbcr_top.sv
`timescale 1ns/10ps
`include "pmbcr_regs.svh"
module pmbcr_top #(
	parameter logic [6:0] DEV_ADDR = 7'h20
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out_q,
	output logic             sda_oe_b_q,
	input  wire logic        power_control_pin,
	output logic             conv_enable_q,
	output logic [15:0]      vout_target_q,
	output logic [15:0]      slew_rate_q,
	output logic [15:0]      scale_q,
	output logic [15:0]      input_start_threshold_q,
	output logic [15:0]      input_stop_threshold_q,
	output logic [7:0]       alert_mask_q,
	output logic             fault_clear_q
);

	// Check byte runs over every byte of a transfer, addresses included,
	// so a repeated start must not restart it
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ `PMBCR_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : crc8

	// Length class of each command; the bad class gates both reads and writes,
	// so a code missing here can never reach a register
	function automatic pmbcr_pkg::pmbcr_len_t cmd_len(input logic [7:0] c);
		case (c)
			`PMBCR_CMD_CLR, `PMBCR_CMD_STORE_D, `PMBCR_CMD_RESTORE_D,
			`PMBCR_CMD_STORE_U, `PMBCR_CMD_RESTORE_U: return pmbcr_pkg::PMBCR_LEN_SEND;
			`PMBCR_CMD_OP, `PMBCR_CMD_ONOFF, `PMBCR_CMD_WP, `PMBCR_CMD_CAP,
			`PMBCR_CMD_MASK, `PMBCR_CMD_MODE: return pmbcr_pkg::PMBCR_LEN_BYTE;
			`PMBCR_CMD_VCMD, `PMBCR_CMD_VMAX, `PMBCR_CMD_RATE, `PMBCR_CMD_SCALE,
			`PMBCR_CMD_VMIN, `PMBCR_CMD_INPUT_START_THRESHOLD,
			`PMBCR_CMD_INPUT_STOP_THRESHOLD: return pmbcr_pkg::PMBCR_LEN_WORD;
			default: return pmbcr_pkg::PMBCR_LEN_BAD;
		endcase
	endfunction : cmd_len

	// Ceiling is tested first, so it wins for a setpoint above it if the host leaves the limits crossed;
	// a setpoint at or below the ceiling then gets the floor, which lies above it
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
			input logic [15:0] hi);
		if (v > hi)
			return hi;
		else if (v < lo)
			return lo;
		return v;
	endfunction : clamp

	// Restored limits follow the scaling ratio; an unlisted ratio falls back
	// to the ratio-1 limits, the narrowest window
	function automatic logic [15:0] vmax_for(input logic [15:0] s);
		case (s)
			`PMBCR_SCALE_S05: return `PMBCR_VMAX_S05;
			`PMBCR_SCALE_S025: return `PMBCR_VMAX_S025;
			default: return `PMBCR_VMAX_S1;
		endcase
	endfunction : vmax_for

	function automatic logic [15:0] vmin_for(input logic [15:0] s);
		case (s)
			`PMBCR_SCALE_S05: return `PMBCR_VMIN_S05;
			`PMBCR_SCALE_S025: return `PMBCR_VMIN_S025;
			default: return `PMBCR_VMIN_S1;
		endcase
	endfunction : vmin_for

	// Pin samples and one-cycle-old copies for edge detection
	logic                    scl_q;
	logic                    sda_q;
	logic                    scl_p_q;
	logic                    sda_p_q;
	pmbcr_pkg::pmbcr_state_t state_q;
	logic [3:0]              cnt_q;
	logic [1:0]              idx_q;
	logic [7:0]              sh_q;
	logic [7:0]              cmd_q;
	logic                    rd_q;
	logic [1:0]              wcnt_q;
	logic [7:0]              wbuf_q [3];
	logic [7:0]              crc_q;
	logic [7:0]              tx_sh_q;
	logic [1:0]              txi_q;
	logic                    nack_q;
	logic                    exec_q;

	// Shadow copies stand in for nonvolatile storage; reset loads the defaults
	// into them, as nothing survives a power cycle here
	logic [7:0]              op_q;
	logic [7:0]              onoff_q;
	logic [7:0]              wp_q;
	logic [15:0]             vcmd_q;
	logic [15:0]             vmax_q;
	logic [15:0]             vmin_q;
	logic [7:0]              nvm_onoff_q;
	logic [7:0]              nvm_wp_q;
	logic [7:0]              nvm_mask_q;
	logic [15:0]             nvm_vcmd_q;
	logic [15:0]             nvm_scale_q;
	logic [15:0]             nvm_input_start_threshold_q;
	logic [15:0]             nvm_input_stop_threshold_q;

	wire                     scl_rise_w;
	wire                     scl_fall_w;
	wire                     start_w;
	wire                     stop_w;
	wire                     addr_hit_w;
	pmbcr_pkg::pmbcr_len_t   sh_len_w;
	pmbcr_pkg::pmbcr_len_t   clen_w;
	wire                     rd_ok_w;
	wire                     wr_done_w;
	wire                     wr_allow_w;
	wire [15:0]              wdata_w;
	wire [7:0]               tx_byte_w;
	wire                     pin_on_w;
	logic [15:0]             rd_w;

	assign scl_rise_w = scl_q & ~scl_p_q;
	assign scl_fall_w = ~scl_q & scl_p_q;
	assign start_w    = scl_q & scl_p_q & sda_p_q & ~sda_q;
	assign stop_w     = scl_q & scl_p_q & ~sda_p_q & sda_q;
	assign addr_hit_w = sh_q[7:1] == DEV_ADDR;
	assign sh_len_w   = cmd_len(sh_q);
	assign clen_w     = cmd_len(cmd_q);
	assign wdata_w    = {wbuf_q[1], wbuf_q[0]};
	// Write-only and unknown codes have nothing to return, so a read is refused
	assign rd_ok_w    = (clen_w != pmbcr_pkg::PMBCR_LEN_SEND)
		&& (clen_w != pmbcr_pkg::PMBCR_LEN_BAD);
	// Exact length, or one extra byte that must fold the check sum to zero
	assign wr_done_w  = !rd_q && (idx_q == 2'd2) && (clen_w != pmbcr_pkg::PMBCR_LEN_BAD)
		&& ((wcnt_q == clen_w) || ((wcnt_q == 2'(clen_w + 2'd1)) && (crc_q == 8'h00)));
	// Protection register stays writable, otherwise a lock could never be undone
	assign wr_allow_w = (cmd_q == `PMBCR_CMD_WP) || (wp_q == `PMBCR_WP_RST)
		|| ((wp_q == `PMBCR_WP_OPONLY) && (cmd_q == `PMBCR_CMD_OP))
		|| ((wp_q == `PMBCR_WP_CFG) && ((cmd_q == `PMBCR_CMD_OP)
		|| (cmd_q == `PMBCR_CMD_ONOFF) || (cmd_q == `PMBCR_CMD_VCMD)));
	// Word data low byte first, then the check byte, then idle ones
	assign tx_byte_w  = (txi_q == 2'd0) ? rd_w[7:0]
		: ((txi_q == 2'd1) && (clen_w == pmbcr_pkg::PMBCR_LEN_WORD)) ? rd_w[15:8]
		: (txi_q == clen_w) ? crc_q : 8'hff;
	// Polarity bit set means the control pin is active high
	assign pin_on_w   = power_control_pin == onoff_q[`PMBCR_CFG_POL_BIT];

	// Read selection; codes with no readable value return all ones,
	// which is also what an idle line would show
	always_comb begin
		case (cmd_q)
			`PMBCR_CMD_OP: rd_w = {8'h00, op_q};
			`PMBCR_CMD_ONOFF: rd_w = {8'h00, onoff_q};
			`PMBCR_CMD_WP: rd_w = {8'h00, wp_q};
			`PMBCR_CMD_CAP: rd_w = {8'h00, `PMBCR_CAP_VAL};
			`PMBCR_CMD_MASK: rd_w = {8'h00, alert_mask_q};
			`PMBCR_CMD_MODE: rd_w = {8'h00, `PMBCR_MODE_VAL};
			`PMBCR_CMD_VCMD: rd_w = vcmd_q;
			`PMBCR_CMD_VMAX: rd_w = vmax_q;
			`PMBCR_CMD_RATE: rd_w = slew_rate_q;
			`PMBCR_CMD_SCALE: rd_w = scale_q;
			`PMBCR_CMD_VMIN: rd_w = vmin_q;
			`PMBCR_CMD_INPUT_START_THRESHOLD: rd_w = input_start_threshold_q;
			`PMBCR_CMD_INPUT_STOP_THRESHOLD: rd_w = input_stop_threshold_q;
			default: rd_w = 16'hffff;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_q   <= scl_in;
			sda_q   <= sda_in;
			scl_p_q <= scl_q;
			sda_p_q <= sda_q;
		end
	end

	// Bus engine; the line only changes after a falling clock edge is seen
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q    <= pmbcr_pkg::PMBCR_IDLE;
			cnt_q      <= 4'h0;
			idx_q      <= 2'd0;
			sh_q       <= 8'h00;
			cmd_q      <= 8'h00;
			rd_q       <= 1'b0;
			wcnt_q     <= 2'd0;
			wbuf_q     <= '{default: 8'h00};
			crc_q      <= 8'h00;
			tx_sh_q    <= 8'h00;
			txi_q      <= 2'd0;
			nack_q     <= 1'b0;
			exec_q     <= 1'b0;
			sda_out_q  <= 1'b0;
			sda_oe_b_q <= 1'b1;
		end else begin
			exec_q    <= 1'b0;
			sda_out_q <= 1'b0;
			if (stop_w) begin
				exec_q     <= (state_q != pmbcr_pkg::PMBCR_IDLE) && wr_done_w;
				state_q    <= pmbcr_pkg::PMBCR_IDLE;
				sda_oe_b_q <= 1'b1;
			end else if (start_w) begin
				// A repeated start keeps the check sum running
				if (state_q == pmbcr_pkg::PMBCR_IDLE)
					crc_q <= 8'h00;
				state_q    <= pmbcr_pkg::PMBCR_RX;
				cnt_q      <= 4'h0;
				idx_q      <= 2'd0;
				rd_q       <= 1'b0;
				sda_oe_b_q <= 1'b1;
			end else if (scl_rise_w && (state_q != pmbcr_pkg::PMBCR_IDLE)) begin
				if (cnt_q < 4'd8)
					sh_q <= {sh_q[6:0], sda_q};
				if ((cnt_q == 4'd8) && (state_q == pmbcr_pkg::PMBCR_TX))
					nack_q <= sda_q;
				cnt_q <= cnt_q + 4'd1;
			end else if (scl_fall_w && (state_q == pmbcr_pkg::PMBCR_RX) && (cnt_q == 4'd8)) begin
				sda_oe_b_q <= 1'b1;
				case (idx_q)
					2'd0: begin
						crc_q <= crc8(crc_q, sh_q);
						rd_q  <= sh_q[0];
						idx_q <= 2'd1;
						txi_q <= 2'd0;
						nack_q <= 1'b0;
						if (addr_hit_w && (!sh_q[0] || rd_ok_w)) begin
							sda_oe_b_q <= 1'b0;
							if (sh_q[0])
								state_q <= pmbcr_pkg::PMBCR_TX;
						end else begin
							state_q <= pmbcr_pkg::PMBCR_SKIP;
						end
					end
					// Command byte; an unknown code is nacked here so nothing lands
					2'd1: begin
						cmd_q  <= sh_q;
						wcnt_q <= 2'd0;
						idx_q  <= 2'd2;
						if (sh_len_w != pmbcr_pkg::PMBCR_LEN_BAD) begin
							crc_q      <= crc8(crc_q, sh_q);
							sda_oe_b_q <= 1'b0;
						end else begin
							state_q <= pmbcr_pkg::PMBCR_SKIP;
						end
					end
					// Data bytes; a fourth is nacked, as no command carries that many
					default: begin
						if (wcnt_q != 2'd3) begin
							wbuf_q[wcnt_q] <= sh_q;
							wcnt_q         <= wcnt_q + 2'd1;
							crc_q          <= crc8(crc_q, sh_q);
							sda_oe_b_q     <= 1'b0;
						end else begin
							state_q <= pmbcr_pkg::PMBCR_SKIP;
						end
					end
				endcase
			end else if (scl_fall_w && (state_q == pmbcr_pkg::PMBCR_TX)) begin
				// Ninth falling edge: load the next byte unless the host declined
				if (cnt_q == 4'd9) begin
					cnt_q <= 4'h0;
					if (nack_q) begin
						// Host declined more data; wait for its stop
						state_q    <= pmbcr_pkg::PMBCR_SKIP;
						sda_oe_b_q <= 1'b1;
					end else begin
						tx_sh_q    <= {tx_byte_w[6:0], 1'b0};
						sda_oe_b_q <= tx_byte_w[7];
						crc_q      <= crc8(crc_q, tx_byte_w);
						txi_q      <= (txi_q == 2'd3) ? txi_q : txi_q + 2'd1;
					end
				end else if (cnt_q == 4'd8) begin
					sda_oe_b_q <= 1'b1;
				end else begin
					tx_sh_q    <= {tx_sh_q[6:0], 1'b0};
					sda_oe_b_q <= tx_sh_q[7];
				end
			end else if (scl_fall_w && (cnt_q == 4'd9)) begin
				cnt_q      <= 4'h0;
				sda_oe_b_q <= 1'b1;
			end
		end
	end

	// Settings; a committed write lands two cycles after the stop is decoded
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			op_q          <= `PMBCR_OP_RST;
			onoff_q       <= `PMBCR_ONOFF_RST;
			wp_q          <= `PMBCR_WP_RST;
			alert_mask_q  <= `PMBCR_MASK_RST;
			vcmd_q        <= `PMBCR_VCMD_RST;
			vmax_q        <= `PMBCR_VMAX_S1;
			vmin_q        <= `PMBCR_VMIN_S1;
			slew_rate_q   <= `PMBCR_RATE_RST;
			scale_q       <= `PMBCR_SCALE_S1;
			input_start_threshold_q      <= `PMBCR_INPUT_START_THRESHOLD_RST;
			input_stop_threshold_q     <= `PMBCR_INPUT_STOP_THRESHOLD_RST;
			nvm_onoff_q   <= `PMBCR_ONOFF_RST;
			nvm_wp_q      <= `PMBCR_WP_RST;
			nvm_mask_q    <= `PMBCR_MASK_RST;
			nvm_vcmd_q    <= `PMBCR_VCMD_RST;
			nvm_scale_q   <= `PMBCR_SCALE_S1;
			nvm_input_start_threshold_q  <= `PMBCR_INPUT_START_THRESHOLD_RST;
			nvm_input_stop_threshold_q <= `PMBCR_INPUT_STOP_THRESHOLD_RST;
			fault_clear_q <= 1'b0;
		end else begin
			// Blocked writes are still acked on the bus; protection only stops
			// the commit, so the host must read back to see the effect
			fault_clear_q <= exec_q && wr_allow_w && (cmd_q == `PMBCR_CMD_CLR);
			if (exec_q && wr_allow_w) begin
				case (cmd_q)
					`PMBCR_CMD_OP: op_q <= wbuf_q[0];
					`PMBCR_CMD_ONOFF: onoff_q <= wbuf_q[0];
					`PMBCR_CMD_WP: wp_q <= wbuf_q[0];
					`PMBCR_CMD_MASK: alert_mask_q <= wbuf_q[0];
					`PMBCR_CMD_VCMD: vcmd_q <= clamp(wdata_w, vmin_q, vmax_q);
					`PMBCR_CMD_VMAX: vmax_q <= wdata_w;
					`PMBCR_CMD_RATE: slew_rate_q <= wdata_w;
					`PMBCR_CMD_SCALE: scale_q <= wdata_w;
					`PMBCR_CMD_VMIN: vmin_q <= wdata_w;
					`PMBCR_CMD_INPUT_START_THRESHOLD: input_start_threshold_q <= wdata_w;
					`PMBCR_CMD_INPUT_STOP_THRESHOLD: input_stop_threshold_q <= wdata_w;
					`PMBCR_CMD_STORE_D, `PMBCR_CMD_STORE_U: begin
						nvm_onoff_q   <= onoff_q;
						nvm_wp_q      <= wp_q;
						nvm_mask_q    <= alert_mask_q;
						nvm_vcmd_q    <= vcmd_q;
						nvm_scale_q   <= scale_q;
						nvm_input_start_threshold_q  <= input_start_threshold_q;
						nvm_input_stop_threshold_q <= input_stop_threshold_q;
					end
					`PMBCR_CMD_RESTORE_D, `PMBCR_CMD_RESTORE_U: begin
						onoff_q      <= nvm_onoff_q;
						wp_q         <= nvm_wp_q;
						alert_mask_q <= nvm_mask_q;
						vcmd_q       <= nvm_vcmd_q;
						scale_q      <= nvm_scale_q;
						input_start_threshold_q     <= nvm_input_start_threshold_q;
						input_stop_threshold_q    <= nvm_input_stop_threshold_q;
						vmax_q       <= vmax_for(nvm_scale_q);
						vmin_q       <= vmin_for(nvm_scale_q);
					end
					default: op_q <= op_q;
				endcase
			end
		end
	end

	// Limits are re-applied continuously, so a later ceiling or floor write also bites
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			conv_enable_q <= 1'b0;
			vout_target_q <= `PMBCR_VCMD_RST;
		end else begin
			conv_enable_q <= !onoff_q[`PMBCR_CFG_PU_BIT]
				|| ((!onoff_q[`PMBCR_CFG_CMD_BIT] || op_q[`PMBCR_OP_ON_BIT])
				&& (!onoff_q[`PMBCR_CFG_CP_BIT] || pin_on_w));
			vout_target_q <= clamp(vcmd_q, vmin_q, vmax_q);
		end
	end

endmodule : pmbcr_top

//--- tb/pmbcr_top_props.sv
`timescale 1ns/10ps
module pmbcr_top_props (
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        sda_out_q,
	input wire logic        sda_oe_b_q,
	input wire logic        fault_clear_q,
	input wire logic [15:0] vout_target_q,
	input wire logic [15:0] slew_rate_q,
	input wire logic [15:0] scale_q,
	input wire logic [15:0] input_start_threshold_q,
	input wire logic [15:0] input_stop_threshold_q,
	input wire logic [7:0]  alert_mask_q
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	property p_clear_pulse;
		$rose(fault_clear_q) |=> !fault_clear_q [*2];
	endproperty
	a_clear_pulse: assert property (p_clear_pulse)
		else $error("fault clear pulse too long");
	// Commits belong to the stop condition, so the bus is idle-high around them
	property p_clear_idle;
		fault_clear_q |-> scl_in && sda_in && $past(scl_in, 3);
	endproperty
	a_clear_idle: assert property (p_clear_idle)
		else $error("fault clear outside a stop");
	property p_scale_hold;
		!$stable(scale_q) |-> scl_in && sda_in;
	endproperty
	a_scale_hold: assert property (p_scale_hold)
		else $error("scaling ratio changed mid transfer");
	property p_slew_hold;
		$changed(slew_rate_q) |-> $past(sda_in) && scl_in;
	endproperty
	a_slew_hold: assert property (p_slew_hold)
		else $error("slew rate changed mid transfer");
	property p_input_start_threshold;
		input_start_threshold_q != $past(input_start_threshold_q) |-> scl_in ##1 scl_in;
	endproperty
	a_input_start_threshold: assert property (p_input_start_threshold)
		else $error("start threshold changed mid transfer");
	property p_input_stop_threshold;
		$changed(input_stop_threshold_q) |-> $past(scl_in, 2) && $past(sda_in);
	endproperty
	a_input_stop_threshold: assert property (p_input_stop_threshold)
		else $error("stop threshold changed mid transfer");
	property p_mask_once;
		$changed(alert_mask_q) |=> $stable(alert_mask_q) [*4];
	endproperty
	a_mask_once: assert property (p_mask_once)
		else $error("alert mask changed twice in a row");
	property p_vout_stop;
		$changed(vout_target_q) |-> $past(scl_in, 3) && scl_in;
	endproperty
	a_vout_stop: assert property (p_vout_stop)
		else $error("setpoint changed mid transfer");
	property p_oe_clk_low;
		$changed(sda_oe_b_q) |-> !scl_in;
	endproperty
	a_oe_clk_low: assert property (p_oe_clk_low)
		else $error("data line changed with clock high");
	property p_drive_len;
		$fell(sda_oe_b_q) |-> !sda_out_q ##1 !sda_oe_b_q [*3];
	endproperty
	a_drive_len: assert property (p_drive_len)
		else $error("data drive too short");
endmodule : pmbcr_top_props

bind pmbcr_top pmbcr_top_props pmbcr_top_props_i (
	.ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out_q(sda_out_q), .sda_oe_b_q(sda_oe_b_q), .fault_clear_q(fault_clear_q),
	.vout_target_q(vout_target_q), .slew_rate_q(slew_rate_q), .scale_q(scale_q),
	.input_start_threshold_q(input_start_threshold_q), .input_stop_threshold_q(input_stop_threshold_q), .alert_mask_q(alert_mask_q));

//--- tb/pmbcr_host.sv
`timescale 1ns/10ps
module pmbcr_host (
	input  wire logic ref_clk,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_rel
);
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// Eight cycles a phase keeps well above the four-cycle minimum
	task half;
		repeat (8) @(posedge ref_clk);
		#2;
	endtask : half
	// Data moves two cycles after the clock falls, never in the same sample
	task fall;
		scl = 1'b0;
		repeat (2) @(posedge ref_clk);
		#2;
	endtask : fall
	task start;
		half();
		sda_rel = 1'b0;
		half();
		fall();
	endtask : start
	task rstart;
		sda_rel = 1'b1;
		half();
		scl = 1'b1;
		start();
	endtask : rstart
	task stop;
		sda_rel = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_rel = 1'b1;
		half();
	endtask : stop
	task bit_io(input logic b, output logic r);
		sda_rel = b;
		half();
		scl = 1'b1;
		half();
		r = sda_wire;
		fall();
	endtask : bit_io
	task byte_io(input logic [7:0] tx, input logic ak_in, output logic [7:0] rx, output logic ak);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(ak_in, ak);
	endtask : byte_io
endmodule : pmbcr_host

//--- tb/pmbcr_top_bench.sv
`timescale 1ns/10ps
module pmbcr_top_bench;
	localparam logic [6:0] ADDR = 7'h20;
	localparam logic [7:0] BC [6] = '{8'h01, 8'h02, 8'h10, 8'h19, 8'h20, 8'h1b};
	localparam logic [7:0] BV [6] = '{8'h00, 8'h16, 8'h00, 8'hb0, 8'h17, 8'h08};
	localparam logic [7:0] WC [7] = '{8'h21, 8'h24, 8'h27, 8'h29, 8'h2b, 8'h35, 8'h36};
	localparam logic [15:0] WV [7] = '{16'h0100, 16'h034d, 16'hd03c, 16'hf004,
		16'h00b3, 16'hf012, 16'hf010};
	localparam logic [7:0] WO [5] = '{8'h03, 8'h11, 8'h12, 8'h15, 8'h16};
	localparam logic [7:0] SC [2] = '{8'h11, 8'h15};
	localparam logic [7:0] RC [2] = '{8'h12, 8'h16};
	localparam logic [15:0] SV [2] = '{16'hf002, 16'hf001};
	localparam logic [15:0] VX [2] = '{16'h069a, 16'h0c00};
	localparam logic [15:0] VN [2] = '{16'h0166, 16'h02cc};
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        pin = 1'b1;
	logic        scl, sda_rel, sda_wire, sda_out_q, sda_oe_b_q, conv_enable_q, fault_clear_q;
	logic        cmd_ak, rd_ak;
	logic [15:0] vout_target_q, slew_rate_q, scale_q, input_start_threshold_q, input_stop_threshold_q, rv;
	logic [7:0]  alert_mask_q;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          n_clr = 0;

	// Open drain with pull-up: low if either side pulls
	assign sda_wire = sda_rel & sda_oe_b_q;
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (fault_clear_q === 1'b1) n_clr++;

	pmbcr_top #(.DEV_ADDR(ADDR)) pmbcr_top_i (.ref_clk(ref_clk), .rst_b(rst_b),
		.scl_in(scl), .sda_in(sda_wire), .sda_out_q(sda_out_q), .sda_oe_b_q(sda_oe_b_q),
		.power_control_pin(pin), .conv_enable_q(conv_enable_q),
		.vout_target_q(vout_target_q), .slew_rate_q(slew_rate_q), .scale_q(scale_q),
		.input_start_threshold_q(input_start_threshold_q), .input_stop_threshold_q(input_stop_threshold_q), .alert_mask_q(alert_mask_q),
		.fault_clear_q(fault_clear_q));
	pmbcr_host pmbcr_host_i (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl),
		.sda_rel(sda_rel));

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
		return r;
	endfunction : crc8

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task conclude;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude

	// pec: 0 none, 1 correct check byte, 2 corrupted check byte
	task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d, input int pec);
		logic [7:0] b [4];
		logic [7:0] c, rx;
		logic       ak;
		b = '{{ADDR, 1'b0}, cmd, d[7:0], d[15:8]};
		c = 8'h00;
		pmbcr_host_i.start();
		for (int i = 0; i < n + 2; i++) begin
			pmbcr_host_i.byte_io(b[i], 1'b1, rx, ak);
			if (i == 1) cmd_ak = ak;
			c = crc8(c, b[i]);
		end
		if (pec == 1) pmbcr_host_i.byte_io(c, 1'b1, rx, ak);
		if (pec == 2) pmbcr_host_i.byte_io(~c, 1'b1, rx, ak);
		pmbcr_host_i.stop();
	endtask : wr

	task automatic rd(input logic [7:0] cmd, input int n);
		logic [7:0] rx;
		logic       ak;
		rv = 16'h0000;
		pmbcr_host_i.start();
		pmbcr_host_i.byte_io({ADDR, 1'b0}, 1'b1, rx, ak);
		pmbcr_host_i.byte_io(cmd, 1'b1, rx, ak);
		pmbcr_host_i.rstart();
		pmbcr_host_i.byte_io({ADDR, 1'b1}, 1'b1, rx, rd_ak);
		for (int i = 0; i < n && rd_ak === 1'b0; i++) begin
			pmbcr_host_i.byte_io(8'hff, i == n - 1, rx, ak);
			rv[8*i +: 8] = rx;
		end
		pmbcr_host_i.stop();
	endtask : rd

	task t_defaults;
		chk(alert_mask_q, 16'h0008);
		chk(vout_target_q, 16'h0100);
		chk(conv_enable_q, 1'b1);
		for (int i = 0; i < 6; i++) begin
			rd(BC[i], 1);
			chk(rv, BV[i]);
		end
		for (int i = 0; i < 7; i++) begin
			rd(WC[i], 2);
			chk(rv, WV[i]);
		end
	endtask : t_defaults

	task t_access;
		wr(8'h19, 1, 16'h00ff, 0);
		rd(8'h19, 1);
		chk(rv, 16'h00b0);
		wr(8'h20, 1, 16'h0000, 0);
		rd(8'h20, 1);
		chk(rv, 16'h0017);
		for (int i = 0; i < 5; i++) begin
			rd(WO[i], 1);
			chk(rd_ak, 1'b1);
		end
		wr(8'h05, 2, 16'h1111, 0);
		chk(cmd_ak, 1'b1);
		chk(input_stop_threshold_q, 16'hf010);
	endtask : t_access

	task t_setpoint;
		wr(8'h21, 2, 16'h0200, 0);
		chk(vout_target_q, 16'h0200);
		rd(8'h21, 2);
		chk(rv, 16'h0200);
		wr(8'h21, 2, 16'h0400, 0);
		chk(vout_target_q, 16'h034d);
		wr(8'h21, 2, 16'h0010, 0);
		chk(vout_target_q, 16'h00b3);
	endtask : t_setpoint

	task t_pec_mask;
		wr(8'h35, 2, 16'hf013, 1);
		chk(input_start_threshold_q, 16'hf013);
		wr(8'h35, 2, 16'hf014, 2);
		chk(input_start_threshold_q, 16'hf013);
		wr(8'h35, 2, 16'hf015, 0);
		chk(input_start_threshold_q, 16'hf015);
		wr(8'h1b, 1, 16'h00ff, 0);
		chk(alert_mask_q, 16'h00ff);
	endtask : t_pec_mask

	task t_protect_clear;
		int k;
		wr(8'h10, 1, 16'h0080, 0);
		wr(8'h36, 2, 16'h1111, 0);
		chk(input_stop_threshold_q, 16'hf010);
		wr(8'h10, 1, 16'h0040, 0);
		wr(8'h02, 1, 16'h0017, 0);
		rd(8'h02, 1);
		chk(rv, 16'h0016);
		wr(8'h10, 1, 16'h0020, 0);
		wr(8'h02, 1, 16'h0017, 0);
		rd(8'h02, 1);
		chk(rv, 16'h0017);
		wr(8'h36, 2, 16'h1111, 0);
		chk(input_stop_threshold_q, 16'hf010);
		wr(8'h02, 1, 16'h0016, 0);
		wr(8'h10, 1, 16'h0000, 0);
		wr(8'h36, 2, 16'h1111, 0);
		chk(input_stop_threshold_q, 16'h1111);
		k = n_clr;
		wr(8'h03, 0, 16'h0000, 0);
		chk(16'(n_clr - k), 16'h0001);
	endtask : t_protect_clear

	// The slew rate is volatile, so a restore must leave the freshly written value
	task t_nvm;
		for (int j = 0; j < 2; j++) begin
			wr(8'h29, 2, SV[j], 0);
			wr(SC[j], 0, 16'h0000, 0);
			wr(8'h29, 2, 16'hf004, 0);
			wr(8'h27, 2, 16'h1234, 0);
			wr(RC[j], 0, 16'h0000, 0);
			chk(scale_q, SV[j]);
			chk(slew_rate_q, 16'h1234);
			chk(input_start_threshold_q, 16'hf015);
			chk(input_stop_threshold_q, 16'h1111);
			chk(vout_target_q, VN[j]);
			rd(8'h24, 2);
			chk(rv, VX[j]);
			rd(8'h2b, 2);
			chk(rv, VN[j]);
		end
	endtask : t_nvm

	task t_enable;
		wr(8'h01, 1, 16'h0080, 0);
		pin = 1'b0;
		pmbcr_host_i.half();
		chk(conv_enable_q, 1'b0);
		pin = 1'b1;
		wr(8'h02, 1, 16'h001e, 0);
		wr(8'h01, 1, 16'h0000, 0);
		chk(conv_enable_q, 1'b0);
		wr(8'h01, 1, 16'h0080, 0);
		chk(conv_enable_q, 1'b1);
	endtask : t_enable

	initial begin
		repeat (16) @(posedge ref_clk);
		#2;
		rst_b = 1'b1;
		pmbcr_host_i.half();
		t_defaults();
		t_access();
		t_setpoint();
		t_pec_mask();
		t_protect_clear();
		t_nvm();
		t_enable();
		conclude();
	end

	initial begin
		repeat (95000) @(posedge ref_clk);
		n_fail++;
		conclude();
	end
endmodule : pmbcr_top_bench
